// *** rtl/pcm_clock_control.v ***
`timescale 1ns/10ps
`default_nettype none
`include "pcm_defs.vh"
// the pll and dividers are modelled as rates: the outputs report the
// selected multiplier/divisor and a limp clock produced from clk_sys.
module pcm_clock_control #(
	parameter LOCK_OSC_CYCLES = `PCM_LOCK_OSC_CYCLES
) (
	// system
	input  wire        clk_sys,
	input  wire        srst,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata_q,
	input  wire        protected_write_enable,
	// clock pins
	input  wire        crystal_in_pin,
	input  wire        ext_clock_3v3_input,
	// clock status outputs
	output reg  [3:0]  clk_mult_q,
	output reg         clk_halve_q,
	output reg         pll_used_q,
	output reg         limp_active_q,
	output reg         limp_clk_q,
	output reg         device_reset_q,
	output reg         wdog_count_en_q,
	output reg         pll_lock_flag_q,
	output reg         missing_clock_flag_q
);
	// =================================================================
	// registers
	reg [3:0]  ratio_q;
	reg        halve_sel_q;
	reg        pdown_q;
	reg [1:0]  src_q;
	reg        wdog_en_q;
	reg [31:0] lock_cnt_q;
	reg        seen_clk_q;
	reg        lost_q;
	reg [15:0] miss_cnt_q;
	reg [15:0] limp_cnt_q;
	reg [7:0]  rst_cnt_q;
	wire       edge_xtal;
	wire       edge_hv;
	wire       osc_edge;
	wire       ratio_wr;
	wire       status_wr;

	// =================================================================
	// oscillator edge detection
	pcm_edge_watch u_xtal (
		.clk_sys (clk_sys),
		.srst    (srst),
		.pin_clk (crystal_in_pin),
		.edge_q  (edge_xtal)
	);

	pcm_edge_watch u_hv (
		.clk_sys (clk_sys),
		.srst    (srst),
		.pin_clk (ext_clock_3v3_input),
		.edge_q  (edge_hv)
	);

	// crystal and low-voltage input share the x1 pin
	assign osc_edge = (src_q == `PCM_SRC_HV) ? edge_hv : edge_xtal;

	// =================================================================
	// register writes
	assign ratio_wr  = reg_wr & (reg_addr == `PCM_ADDR_RATIO) & protected_write_enable;
	assign status_wr = reg_wr & (reg_addr == `PCM_ADDR_STATUS) & protected_write_enable;

	always @(posedge clk_sys) begin
		if (srst) begin
			ratio_q     <= 4'h0;
			halve_sel_q <= 1'b0;
			pdown_q     <= 1'b0;
			src_q       <= `PCM_SRC_XTAL;
			wdog_en_q   <= 1'b1;
		end else begin
			// reserved codes are not stored, ratio keeps its value
			if (ratio_wr && (reg_wdata[3:0] <= `PCM_RATIO_MAX)) begin
				ratio_q <= reg_wdata[3:0];
			end
			if (status_wr) begin
				halve_sel_q <= reg_wdata[`PCM_ST_HALVE];
				pdown_q     <= reg_wdata[`PCM_ST_PDOWN];
			end
			if (reg_wr && (reg_addr == `PCM_ADDR_SRC) && protected_write_enable) begin
				src_q <= reg_wdata[1:0];
			end
			if (reg_wr && (reg_addr == `PCM_ADDR_WDOG) && protected_write_enable) begin
				wdog_en_q <= reg_wdata[0];
			end
		end
	end

	// =================================================================
	// lock counter, counted in oscillator edges
	always @(posedge clk_sys) begin
		if (srst) begin
			lock_cnt_q      <= 32'h0000_0000;
			pll_lock_flag_q <= 1'b0;
		end else if (ratio_wr && (reg_wdata[3:0] <= `PCM_RATIO_MAX)) begin
			lock_cnt_q      <= 32'h0000_0000;
			pll_lock_flag_q <= 1'b0;
		end else if (pdown_q) begin
			lock_cnt_q      <= 32'h0000_0000;
			pll_lock_flag_q <= 1'b0;
		end else if (!pll_lock_flag_q && osc_edge) begin
			if (lock_cnt_q == LOCK_OSC_CYCLES - 1) begin
				pll_lock_flag_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
			end
		end
	end

	// =================================================================
	// missing clock detection
	always @(posedge clk_sys) begin
		if (srst) begin
			seen_clk_q <= 1'b0;
			lost_q     <= 1'b0;
			miss_cnt_q <= 16'h0000;
		end else if (osc_edge) begin
			seen_clk_q <= 1'b1;
			lost_q     <= 1'b0;
			miss_cnt_q <= 16'h0000;
		end else if (seen_clk_q && !pdown_q) begin
			if (miss_cnt_q == `PCM_MISS_TIMEOUT) begin
				lost_q <= 1'b1;
			end else begin
				miss_cnt_q <= miss_cnt_q + 16'h0001;
			end
		end
	end

	// =================================================================
	// missing-clock flag: not cleared by srst, only by software
	// the flag stays undefined until the first clearing write or loss event;
	// srst is ignored so firmware can read the cause after restart
	always @(posedge clk_sys) begin
		if (lost_q && (miss_cnt_q == `PCM_MISS_TIMEOUT) && !osc_edge) begin
			missing_clock_flag_q <= 1'b1;
		end else if (!srst && status_wr && reg_wdata[`PCM_ST_MISSING]) begin
			missing_clock_flag_q <= 1'b0;
		end
	end

	// =================================================================
	// device reset pulse on loss
	always @(posedge clk_sys) begin
		if (srst) begin
			rst_cnt_q      <= 8'h00;
			device_reset_q <= 1'b0;
		end else if (!lost_q) begin
			rst_cnt_q      <= 8'h00;
			device_reset_q <= 1'b0;
		end else if (rst_cnt_q != `PCM_RESET_CYCLES) begin
			rst_cnt_q      <= rst_cnt_q + 8'h01;
			device_reset_q <= 1'b1;
		end else begin
			device_reset_q <= 1'b0;
		end
	end

	// =================================================================
	// limp clock: 100 MHz / (2*25) = 2 MHz
	always @(posedge clk_sys) begin
		if (srst) begin
			limp_cnt_q <= 16'h0000;
			limp_clk_q <= 1'b0;
		end else if (lost_q) begin
			if (limp_cnt_q == `PCM_LIMP_HALF - 16'h0001) begin
				limp_cnt_q <= 16'h0000;
				limp_clk_q <= ~limp_clk_q;
			end else begin
				limp_cnt_q <= limp_cnt_q + 16'h0001;
			end
		end else begin
			limp_cnt_q <= 16'h0000;
			limp_clk_q <= 1'b0;
		end
	end

	// =================================================================
	// clock path selection
	always @(posedge clk_sys) begin
		if (srst) begin
			clk_mult_q      <= 4'h1;
			clk_halve_q     <= 1'b1;
			pll_used_q      <= 1'b0;
			limp_active_q   <= 1'b0;
			wdog_count_en_q <= 1'b0;
		end else begin
			clk_halve_q     <= ~halve_sel_q;
			// limp on loss of the oscillator selected by src_q, pll or bypass, never in power-down
			limp_active_q   <= lost_q & ~pdown_q;
			wdog_count_en_q <= wdog_en_q & ~lost_q;
			if (pdown_q || ratio_q == 4'h0 || !pll_lock_flag_q) begin
				clk_mult_q <= 4'h1;
				pll_used_q <= 1'b0;
			end else begin
				clk_mult_q <= ratio_q;
				pll_used_q <= 1'b1;
			end
		end
	end

	// =================================================================
	// register reads
	always @(posedge clk_sys) begin
		if (srst) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`PCM_ADDR_RATIO:  reg_rdata_q <= {12'h000, ratio_q};
				`PCM_ADDR_STATUS: reg_rdata_q <= {12'h000, missing_clock_flag_q, pdown_q,
					halve_sel_q, pll_lock_flag_q};
				`PCM_ADDR_SRC:    reg_rdata_q <= {14'h0000, src_q};
				`PCM_ADDR_WDOG:   reg_rdata_q <= {15'h0000, wdog_en_q};
				default:          reg_rdata_q <= 16'h0000;
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end
endmodule // pcm_clock_control
`default_nettype wire

// *** rtl/pcm_defs.vh ***
`ifndef PCM_DEFS_VH
`define PCM_DEFS_VH

// =====================================================================
// register indices (word addresses on the register port)
`define PCM_ADDR_RATIO      4'h1
`define PCM_ADDR_STATUS     4'h2
`define PCM_ADDR_SRC        4'h3
`define PCM_ADDR_WDOG       4'h4

// =====================================================================
// status register fields
`define PCM_ST_LOCK         0
`define PCM_ST_HALVE        1
`define PCM_ST_PDOWN        2
`define PCM_ST_MISSING      3

// =====================================================================
// ratio field and reset values
`define PCM_RATIO_W         4
`define PCM_RATIO_MAX       4'ha
`define PCM_RATIO_RST       16'h0000
`define PCM_STATUS_RST      16'h0000

// =====================================================================
// clock source select codes
`define PCM_SRC_XTAL        2'h0
`define PCM_SRC_LV          2'h1
`define PCM_SRC_HV          2'h2

// =====================================================================
// timing
`define PCM_LOCK_OSC_CYCLES 131072
`define PCM_MISS_TIMEOUT    16'h0040
`define PCM_LIMP_HALF       16'h0019
`define PCM_RESET_CYCLES    8'h10

`endif

// *** rtl/pcm_edge_watch.v ***
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// synchronises one oscillator input and reports its rising edges
module pcm_edge_watch (
	// clock and reset
	input  wire clk_sys,
	input  wire srst,
	// raw clock pin
	input  wire pin_clk,
	// one-cycle pulse per rising edge
	output reg  edge_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge clk_sys) begin
		if (srst) begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			s1_q   <= pin_clk;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			edge_q <= s2_q & ~s3_q;
		end
	end
endmodule // pcm_edge_watch
`default_nettype wire

// *** bench/pcm_clock_control_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pcm_defs.vh"
// =====================================================================
// port-level checks for the clock control block
module pcm_clock_control_asserts #(
	parameter LOCK_OSC_CYCLES = 16
) (
	// system
	input wire logic        clk_sys,
	input wire logic        srst,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        protected_write_enable,
	// clock status
	input wire logic [3:0]  clk_mult_q,
	input wire logic        clk_halve_q,
	input wire logic        pll_used_q,
	input wire logic        limp_active_q,
	input wire logic        device_reset_q,
	input wire logic        wdog_count_en_q,
	input wire logic        pll_lock_flag_q,
	input wire logic        missing_clock_flag_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire st_wr = reg_wr & protected_write_enable & (reg_addr == `PCM_ADDR_STATUS);
	wire rt_wr = reg_wr & protected_write_enable & (reg_addr == `PCM_ADDR_RATIO);
	wire rt_ok = rt_wr & (reg_wdata[15:4] == 12'h000) & (reg_wdata[3:0] != 4'h0) & (reg_wdata[3:0] <= 4'ha);
	// =====================================================================
	// assertions
	AST_RST_BYPASS: assert property (disable iff (1'b0) srst |=> clk_mult_q == 4'h1 && !pll_used_q) else $error("not bypass after reset");
	AST_MULT_RANGE: assert property (clk_mult_q != 4'h0 && clk_mult_q <= 4'ha) else $error("multiplier out of range");
	AST_LOCK_WAIT: assert property (rt_ok |=> !pll_lock_flag_q [*8]) else $error("lock too early");
	AST_BYPASS_RELOCK: assert property (rt_ok |-> ##[1:2] !pll_used_q) else $error("pll used while relocking");
	AST_HALVE_SEL: assert property (st_wr |=> ##1 clk_halve_q == !$past(reg_wdata[1], 2)) else $error("halve select wrong");
	AST_PROTECT: assert property (reg_wr && !protected_write_enable |=> ##1 $stable(clk_halve_q)) else $error("unprotected write took");
	AST_LOSS_RESET: assert property ($rose(device_reset_q) |-> device_reset_q [*8] ##0 missing_clock_flag_q) else $error("loss reset short");
	AST_WDOG_FREEZE: assert property (limp_active_q && $past(limp_active_q) |-> !wdog_count_en_q) else $error("watchdog runs in limp");
	AST_LIMP_ROUTE: assert property (limp_active_q && $past(limp_active_q) |-> !pll_used_q) else $error("pll used in limp");
	AST_MISS_STICKY: assert property (missing_clock_flag_q && !(st_wr && reg_wdata[3]) |=> missing_clock_flag_q) else $error("flag lost");
	COV_LOCK: cover property ($rose(pll_lock_flag_q));
	COV_LOSS: cover property ($rose(device_reset_q));
	COV_HALVE: cover property (st_wr && reg_wdata[1]);
endmodule // pcm_clock_control_asserts
`default_nettype wire

// *** bench/test_pcm_clock_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pcm_defs.vh"
module test_pcm_clock_control;
	localparam LOCK_OSC_CYCLES = 16;
	logic        clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, protected_write_enable = 1;
	logic        crystal_in_pin = 0, ext_clock_3v3_input = 0, xtal_on = 1, ext_on = 0;
	logic [3:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, rdv;
	logic [1:0]  ph = 0;
	wire  [15:0] reg_rdata_q;
	wire  [3:0]  clk_mult_q;
	wire         clk_halve_q, pll_used_q, limp_active_q, limp_clk_q, device_reset_q;
	wire         wdog_count_en_q, pll_lock_flag_q, missing_clock_flag_q;
	int          fail_count = 0, n_checks = 0, cyc = 0, n, k;
	pcm_clock_control #(.LOCK_OSC_CYCLES(LOCK_OSC_CYCLES)) DUT (.clk_sys(clk_sys), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.protected_write_enable(protected_write_enable), .crystal_in_pin(crystal_in_pin),
		.ext_clock_3v3_input(ext_clock_3v3_input), .clk_mult_q(clk_mult_q), .clk_halve_q(clk_halve_q),
		.pll_used_q(pll_used_q), .limp_active_q(limp_active_q), .limp_clk_q(limp_clk_q),
		.device_reset_q(device_reset_q), .wdog_count_en_q(wdog_count_en_q),
		.pll_lock_flag_q(pll_lock_flag_q), .missing_clock_flag_q(missing_clock_flag_q));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// oscillator pins run at a quarter of the system clock; stopped pins sit low
	always @(posedge clk_sys) begin
		ph <= ph + 2'h1;
		crystal_in_pin <= xtal_on & ph[1];
		ext_clock_3v3_input <= ext_on & ph[1];
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1; reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 rdv = reg_rdata_q;
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		wait_cyc(8);
		srst <= 0;
		wait_cyc(2);
		chk(clk_mult_q, 1);
		chk(pll_used_q, 0);
		rd(`PCM_ADDR_RATIO); chk(rdv, 0);
		$display("test reset done");
		protected_write_enable <= 0;
		wr(`PCM_ADDR_RATIO, 16'h0005);
		wr(`PCM_ADDR_STATUS, 16'h0002); protected_write_enable <= 1;
		rd(`PCM_ADDR_RATIO); chk(rdv, 0);
		chk(clk_halve_q, 1);
		wr(`PCM_ADDR_RATIO, 16'h000b); rd(`PCM_ADDR_RATIO); chk(rdv, 0);
		$display("test refusal done");
		wr(`PCM_ADDR_WDOG, 16'h0000);
		for (k = 1; k <= 10; k++) begin
			wr(`PCM_ADDR_RATIO, k[15:0]);
			wait_cyc(2); chk(pll_used_q, 0);
			n = 0;
			while (pll_lock_flag_q !== 1'b1 && n < 400) begin wait_cyc(1); n++; end
			chk(n >= 56, 1);
			wait_cyc(2); chk(clk_mult_q, k[3:0]);
			chk(pll_used_q, 1);
		end
		wr(`PCM_ADDR_WDOG, 16'h0001);
		wr(`PCM_ADDR_STATUS, 16'h0002); wait_cyc(1); chk(clk_halve_q, 0);
		wr(`PCM_ADDR_STATUS, 16'h0000); wait_cyc(1); chk(clk_halve_q, 1);
		$display("test ratios done");
		wr(`PCM_ADDR_RATIO, 16'h0000);
		wr(`PCM_ADDR_STATUS, 16'h0004); wait_cyc(2);
		chk(pll_used_q, 0); chk(clk_mult_q, 1);
		wr(`PCM_ADDR_STATUS, 16'h0000);
		wr(`PCM_ADDR_SRC, {14'h0000, `PCM_SRC_HV}); xtal_on <= 0; ext_on <= 1;
		wait_cyc(200); chk(limp_active_q, 0); chk(device_reset_q, 0);
		chk(wdog_count_en_q, 1);
		$display("test source done");
		ext_on <= 0; n = 0;
		while (device_reset_q !== 1'b1 && n < 200) begin wait_cyc(1); n++; end
		chk(n >= 60, 1);
		wait_cyc(3); chk(missing_clock_flag_q, 1);
		chk(limp_active_q, 1); chk(wdog_count_en_q, 0); chk(pll_used_q, 0);
		n = 0;
		for (k = 0; k < 400; k++) begin rdv[0] = limp_clk_q; wait_cyc(1); if (limp_clk_q !== rdv[0]) n++; end
		chk(n >= 8 && n <= 40, 1);
		ext_on <= 1; wait_cyc(20); srst <= 1; wait_cyc(2); srst <= 0; wait_cyc(2);
		chk(missing_clock_flag_q, 1);
		wr(`PCM_ADDR_STATUS, 16'h0008); wait_cyc(2); chk(missing_clock_flag_q, 0);
		$display("test loss done");
		tally_and_finish();
	end
endmodule // test_pcm_clock_control
bind pcm_clock_control pcm_clock_control_asserts #(.LOCK_OSC_CYCLES(LOCK_OSC_CYCLES)) u_chk (.clk_sys(clk_sys),
	.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.protected_write_enable(protected_write_enable), .clk_mult_q(clk_mult_q), .clk_halve_q(clk_halve_q),
	.pll_used_q(pll_used_q), .limp_active_q(limp_active_q), .device_reset_q(device_reset_q),
	.wdog_count_en_q(wdog_count_en_q), .pll_lock_flag_q(pll_lock_flag_q), .missing_clock_flag_q(missing_clock_flag_q));
`default_nettype wire
